// File: hdl/stw_pkg.sv
package stw_pkg;
    localparam int DATA_W = 8;
    localparam int REG_AW = 16;
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam int CNT_W = 4;

    localparam logic [6:0] DEV_ADDR_DEF = 7'h10;
    localparam logic [6:0] DEV_ADDR_ALT = 7'h18;

    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_LAST = 4'h7;
    localparam logic [CNT_W-1:0] CNT_ACK = 4'h8;

    localparam logic [REG_AW-1:0] ADDR_RST = 16'h0000;
    localparam logic [REG_AW-1:0] ADDR_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HEADER = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_WDATA = 3'b100,
        ST_RDATA = 3'b101,
        ST_IGNORE = 3'b110
    } stw_state_type;

    // States whose bytes move register data
    function automatic logic stw_is_data(input stw_state_type st);
        return (st == ST_WDATA) || (st == ST_RDATA);
    endfunction
endpackage

// File: hdl/stw_regmem.sv
`timescale 1ns/10ps
module stw_regmem import stw_pkg::*; (
    input wire logic clk_i, // System clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic wr_en_i, // Write strobe
    input wire logic [MEM_AW-1:0] waddr_i, // Write address
    input wire logic [DATA_W-1:0] wdata_i, // Write data
    input wire logic [MEM_AW-1:0] raddr_i, // Read address
    output logic [DATA_W-1:0] rdata_o // Registered read data
);
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= BYTE_RST;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule

// File: hdl/stw_slave.sv
`timescale 1ns/10ps
module stw_slave import stw_pkg::*; (
    input wire logic clk_i, // System clock, 200 MHz
    input wire logic arst_n_i, // Async reset, active low
    input wire logic scl_i, // Serial clock line, input only
    input wire logic serial_data_line_i, // Data line level
    output logic serial_data_line_o, // Data line drive value
    output logic serial_data_line_oe_o, // Data line pulled low when high
    input wire logic address_select_enable_i, // Enables the select input
    input wire logic address_select_input_i, // Selects alternate address
    output logic reg_wr_o, // One-cycle register write strobe
    output logic [REG_AW-1:0] reg_waddr_o, // Address of the write
    output logic [DATA_W-1:0] reg_wdata_o, // Data of the write
    output logic [REG_AW-1:0] reg_addr_o, // Current internal address
    output logic busy_o // Transfer in progress
);
    logic scl_q;
    logic sda_q;
    stw_state_type state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [DATA_W-1:0] rx_reg;
    logic [DATA_W-1:0] tx_reg;
    logic ack_reg;
    logic rw_reg;
    logic [REG_AW-1:0] addr_reg;
    logic [DATA_W-1:0] addr_hi_reg;
    logic oe_reg;
    logic wr_reg;
    logic [REG_AW-1:0] waddr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] mem_rdata;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_end;
    logic ack_end;
    logic mem_wr;
    logic tx_load;
    logic [DATA_W-1:0] byte_in;
    logic [6:0] own_addr;

    // Clock is sampled only; nothing here drives it
    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_det = scl_i & scl_q & sda_q & ~serial_data_line_i;
    assign stop_det = scl_i & scl_q & ~sda_q & serial_data_line_i;
    assign byte_in = {rx_reg[DATA_W-2:0], serial_data_line_i};
    assign byte_end = scl_rise && (cnt_reg == CNT_LAST) && (state_reg != ST_IDLE);
    assign ack_end = scl_rise && (cnt_reg == CNT_ACK) && (state_reg != ST_IDLE);
    assign own_addr = (address_select_enable_i && address_select_input_i) ?
                      DEV_ADDR_ALT : DEV_ADDR_DEF;
    assign mem_wr = byte_end && (state_reg == ST_WDATA);
    // Load next read byte at the ack edge; data already fetched after increment
    assign tx_load = ack_end && (((state_reg == ST_HEADER) && ack_reg && rw_reg) ||
                     ((state_reg == ST_RDATA) && !serial_data_line_i));

    assign serial_data_line_o = 1'b0;
    assign serial_data_line_oe_o = oe_reg;
    assign reg_wr_o = wr_reg;
    assign reg_waddr_o = waddr_reg;
    assign reg_wdata_o = wdata_reg;
    assign reg_addr_o = addr_reg;
    assign busy_o = (state_reg != ST_IDLE);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= serial_data_line_i;
        end
    end

    // Byte sequencing
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= CNT_ZERO;
        end else if (start_det) begin
            state_reg <= ST_HEADER;
            cnt_reg <= CNT_ZERO;
        end else if (stop_det) begin
            state_reg <= ST_IDLE;
            cnt_reg <= CNT_ZERO;
        end else if (state_reg != ST_IDLE && scl_rise) begin
            if (cnt_reg == CNT_ACK) begin
                cnt_reg <= CNT_ZERO;
                case (state_reg)
                    ST_HEADER: begin
                        if (!ack_reg) begin
                            state_reg <= ST_IGNORE;
                        end else if (rw_reg) begin
                            state_reg <= ST_RDATA;
                        end else begin
                            state_reg <= ST_ADDR_HI;
                        end
                    end
                    ST_ADDR_HI: begin
                        state_reg <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        state_reg <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (serial_data_line_i) begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                    default: begin
                        state_reg <= state_reg;
                    end
                endcase
            end else begin
                cnt_reg <= cnt_reg + CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_reg <= BYTE_RST;
        end else if (scl_rise && cnt_reg < CNT_ACK) begin
            rx_reg <= byte_in;
        end
    end

    // Acknowledge decision per received byte
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_reg <= 1'b0;
            rw_reg <= 1'b0;
        end else if (start_det || stop_det) begin
            ack_reg <= 1'b0;
        end else if (byte_end) begin
            case (state_reg)
                ST_HEADER: begin
                    ack_reg <= (byte_in[DATA_W-1:1] == own_addr);
                    rw_reg <= byte_in[0];
                end
                ST_ADDR_HI, ST_ADDR_LO: begin
                    ack_reg <= 1'b1;
                end
                ST_WDATA: begin
                    ack_reg <= 1'b1;
                end
                default: begin
                    ack_reg <= 1'b0;
                end
            endcase
        end
    end

    // Internal register address
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_reg <= ADDR_RST;
            addr_hi_reg <= BYTE_RST;
        end else if (byte_end) begin
            if (state_reg == ST_ADDR_HI) begin
                addr_hi_reg <= byte_in;
            end else if (state_reg == ST_ADDR_LO) begin
                addr_reg <= {addr_hi_reg, byte_in};
            end else if (stw_is_data(state_reg)) begin
                addr_reg <= addr_reg + ADDR_ONE;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_reg <= 1'b0;
            waddr_reg <= ADDR_RST;
            wdata_reg <= BYTE_RST;
        end else begin
            wr_reg <= mem_wr;
            if (mem_wr) begin
                waddr_reg <= addr_reg;
                wdata_reg <= byte_in;
            end
        end
    end

    // Read shifter, MSB first
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_reg <= BYTE_RST;
        end else if (tx_load) begin
            tx_reg <= mem_rdata;
        end else if (scl_rise && state_reg == ST_RDATA && cnt_reg < CNT_ACK) begin
            tx_reg <= {tx_reg[DATA_W-2:0], 1'b0};
        end
    end

    // Data line drive changes after a clock fall, or is released on a start or stop
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oe_reg <= 1'b0;
        end else if (start_det || stop_det) begin
            oe_reg <= 1'b0;
        end else if (scl_fall) begin
            oe_reg <= ((cnt_reg == CNT_ACK) && ack_reg) ||
                      ((state_reg == ST_RDATA) && (cnt_reg < CNT_ACK) &&
                       !tx_reg[DATA_W-1]);
        end
    end

    stw_regmem u_mem (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_en_i(mem_wr),
        .waddr_i(addr_reg[MEM_AW-1:0]),
        .wdata_i(byte_in),
        .raddr_i(addr_reg[MEM_AW-1:0]),
        .rdata_o(mem_rdata)
    );

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence seq_header_end;
        byte_end && state_reg == ST_HEADER;
    endsequence

    sequence seq_ack_fall;
        scl_fall && cnt_reg == CNT_ACK && !start_det && !stop_det;
    endsequence

    sequence seq_read_nack;
        ack_end && state_reg == ST_RDATA && serial_data_line_i && !start_det && !stop_det;
    endsequence

    a_header_match: assert property (
        seq_header_end ##0 (byte_in[DATA_W-1:1] == own_addr && !start_det && !stop_det)
        |=> ack_reg)
        else $error("matching header not acknowledged");

    a_header_mismatch: assert property (
        seq_header_end ##0 (byte_in[DATA_W-1:1] != own_addr) |=> !ack_reg)
        else $error("foreign header acknowledged");

    a_ignore_released: assert property (
        state_reg == ST_IGNORE |-> !serial_data_line_oe_o)
        else $error("data line driven while ignoring bus");

    a_abort_on_start: assert property (
        start_det |=> state_reg == ST_HEADER && cnt_reg == CNT_ZERO && !oe_reg)
        else $error("start did not restart header reception");

    a_stop_to_idle: assert property (
        stop_det |=> state_reg == ST_IDLE && !serial_data_line_oe_o)
        else $error("stop did not return to idle");

    a_drive_on_low: assert property (
        $changed(serial_data_line_oe_o) |-> !$past(scl_i))
        else $error("data line changed while clock high");

    a_write_ack: assert property (
        seq_ack_fall ##0 (state_reg == ST_WDATA) |=> serial_data_line_oe_o)
        else $error("write data byte not acknowledged");

    a_addr_increment: assert property (
        byte_end && stw_is_data(state_reg) && !start_det && !stop_det
        |=> addr_reg == $past(addr_reg) + ADDR_ONE)
        else $error("register address did not advance");

    a_addr_low_load: assert property (
        byte_end && state_reg == ST_ADDR_LO && !start_det && !stop_det
        |=> addr_reg == {$past(addr_hi_reg), $past(byte_in)})
        else $error("register address not loaded");

    a_write_strobe: assert property (
        mem_wr |=> reg_wr_o && reg_wdata_o == $past(byte_in) &&
        reg_waddr_o == $past(addr_reg) ##1 !reg_wr_o)
        else $error("register write strobe wrong");

    a_read_nack_end: assert property (
        seq_read_nack |=> state_reg == ST_IGNORE ##1 !serial_data_line_oe_o)
        else $error("read not ended by no-acknowledge");

    a_read_ack_slot: assert property (
        seq_ack_fall ##0 (state_reg == ST_RDATA) |=> !serial_data_line_oe_o)
        else $error("slave drove master acknowledge slot");

    a_header_ack_drive: assert property (
        seq_ack_fall ##0 (state_reg == ST_HEADER && ack_reg) |=> serial_data_line_oe_o)
        else $error("address header acknowledge not driven");

    a_foreign_released: assert property (
        seq_ack_fall ##0 (state_reg == ST_HEADER && !ack_reg) |=> !serial_data_line_oe_o)
        else $error("foreign header acknowledge driven");

    a_regaddr_ack: assert property (
        seq_ack_fall ##0 (state_reg == ST_ADDR_HI || state_reg == ST_ADDR_LO)
        |=> serial_data_line_oe_o)
        else $error("register address byte not acknowledged");

    a_read_bit_drive: assert property (
        scl_fall && state_reg == ST_RDATA && cnt_reg < CNT_ACK && !start_det && !stop_det
        |=> serial_data_line_oe_o == !$past(tx_reg[DATA_W-1]))
        else $error("read data bit not driven");
endmodule

// File: tb/stw_master_model.sv
`timescale 1ns/10ps
module stw_master_model (
    input wire logic clk_i, // System clock
    input wire logic sda_i, // Resolved data line
    output logic scl_o, // Serial clock, driven by master only
    output logic sda_oe_o // Pulls data line low when high
);
    localparam int HALF = 6;
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic hold();
        repeat (HALF) @(negedge clk_i);
    endtask
    // Also used mid-byte to force an abort
    task automatic start();
        sda_oe_o = 1'b0;
        hold();
        scl_o = 1'b1;
        hold();
        sda_oe_o = 1'b1;
        hold();
        scl_o = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        hold();
        scl_o = 1'b1;
        hold();
        sda_oe_o = 1'b0;
        hold();
    endtask
    // Data set while clock low, sampled at end of high
    task automatic bit_io(input logic b, output logic r);
        sda_oe_o = ~b;
        hold();
        scl_o = 1'b1;
        hold();
        r = sda_i;
        scl_o = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule

// File: tb/stw_slave_tb.sv
`timescale 1ns/10ps
module stw_slave_tb;
    import stw_pkg::*;
    typedef struct {
        logic en;
        logic sel;
        logic [7:0] hdr;
        logic [15:0] addr;
        logic [7:0] data;
        logic ack;
    } stw_row_type;
    stw_row_type rows [6] = '{
        '{1'b0, 1'b0, 8'h20, 16'h0011, 8'h5A, 1'b1},
        '{1'b0, 1'b1, 8'h20, 16'h0122, 8'hA5, 1'b1},
        '{1'b1, 1'b1, 8'h30, 16'h2333, 8'h0F, 1'b1},
        '{1'b1, 1'b0, 8'h20, 16'hFFFF, 8'hF0, 1'b1},
        '{1'b1, 1'b1, 8'h20, 16'h0055, 8'h00, 1'b0},
        '{1'b0, 1'b0, 8'h30, 16'h0066, 8'h00, 1'b0}
    };
    logic clk_i, arst_n_i, scl, sda, m_oe, sda_o, sda_oe, sel_en, sel, reg_wr, busy, a;
    logic [15:0] reg_waddr, reg_addr, keep;
    logic [7:0] reg_wdata, d;
    int miscompares = 0;
    int num_checks = 0;
    int nwr = 0;
    int nw;
    // Open-drain line with pull-up
    assign sda = (m_oe | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
    stw_slave dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .serial_data_line_i(sda),
        .serial_data_line_o(sda_o), .serial_data_line_oe_o(sda_oe),
        .address_select_enable_i(sel_en), .address_select_input_i(sel),
        .reg_wr_o(reg_wr), .reg_waddr_o(reg_waddr), .reg_wdata_o(reg_wdata),
        .reg_addr_o(reg_addr), .busy_o(busy)
    );
    stw_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    always @(posedge clk_i) begin
        if (reg_wr === 1'b1) nwr <= nwr + 1;
    end
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic seta(input logic [7:0] hdr, input logic [15:0] ad);
        m.start();
        m.wbyte(hdr, a);
        chk(a, 1'b1);
        m.wbyte(ad[15:8], a);
        chk(a, 1'b1);
        m.wbyte(ad[7:0], a);
        chk(a, 1'b1);
    endtask
    task automatic rd(input logic [7:0] hdr, input logic [15:0] ad, input logic [7:0] e);
        seta(hdr, ad);
        m.start();
        m.wbyte(hdr | 8'h01, a);
        chk(a, 1'b1);
        m.rbyte(1'b1, d);
        m.stop();
        chk(d, e);
    endtask
    initial begin
        repeat (50000) @(posedge clk_i);
        miscompares++;
        test_done();
    end
    initial begin
        arst_n_i = 1'b0;
        sel_en = 1'b0;
        sel = 1'b0;
        repeat (16) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk(reg_addr, ADDR_RST);
        chk(busy, 1'b0);
        chk(sda_oe, 1'b0);
        chk(sda_o, 1'b0);
        foreach (rows[i]) begin
            sel_en = rows[i].en;
            sel = rows[i].sel;
            keep = reg_addr;
            if (rows[i].ack) begin
                seta(rows[i].hdr, rows[i].addr);
                nw = nwr;
                m.wbyte(rows[i].data, a);
                m.stop();
                chk(a, 1'b1);
                chk(16'(nwr - nw), 16'h0001);
                chk(reg_waddr, rows[i].addr);
                chk(reg_wdata, rows[i].data);
                chk(reg_addr, rows[i].addr + 16'h0001);
                rd(rows[i].hdr, rows[i].addr, rows[i].data);
                chk(reg_addr, rows[i].addr + 16'h0001);
            end else begin
                m.start();
                m.wbyte(rows[i].hdr, a);
                chk(a, 1'b0);
                m.wbyte(8'h00, a);
                m.stop();
                chk(a, 1'b0);
                chk(reg_addr, keep);
            end
        end
        // Sequential write, then sequential and current reads
        sel_en = 1'b0;
        seta(8'h20, 16'h1240);
        chk(busy, 1'b1);
        nw = nwr;
        for (int i = 0; i < 3; i++) begin
            m.wbyte(8'hA0 + 8'(i), a);
            chk(a, 1'b1);
        end
        m.stop();
        chk(busy, 1'b0);
        chk(16'(nwr - nw), 16'h0003);
        chk(reg_waddr, 16'h1242);
        chk(reg_addr, 16'h1243);
        seta(8'h20, 16'h1240);
        m.start();
        m.wbyte(8'h21, a);
        chk(a, 1'b1);
        for (int i = 0; i < 2; i++) begin
            m.rbyte(i == 1, d);
            chk(d, 8'hA0 + 8'(i));
        end
        m.stop();
        chk(reg_addr, 16'h1242);
        m.start();
        m.wbyte(8'h21, a);
        chk(a, 1'b1);
        m.rbyte(1'b1, d);
        m.stop();
        chk(d, 8'hA2);
        chk(reg_addr, 16'h1243);
        // Stop inside a data byte, then start inside an address byte
        seta(8'h20, 16'h1250);
        nw = nwr;
        repeat (4) m.bit_io(1'b1, a);
        m.stop();
        chk(busy, 1'b0);
        chk(16'(nwr - nw), 16'h0000);
        m.start();
        m.wbyte(8'h20, a);
        repeat (3) m.bit_io(1'b0, a);
        rd(8'h20, 16'h1241, 8'hA1);
        chk(reg_addr, 16'h1242);
        // Reset inside an address byte; memory keeps its contents
        m.start();
        m.wbyte(8'h20, a);
        repeat (2) m.bit_io(1'b0, a);
        arst_n_i = 1'b0;
        @(negedge clk_i);
        chk(busy, 1'b0);
        chk(sda_oe, 1'b0);
        chk(reg_addr, ADDR_RST);
        arst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        m.stop();
        chk(busy, 1'b0);
        rd(8'h20, 16'h1242, 8'hA2);
        chk(reg_addr, 16'h1243);
        test_done();
    end
endmodule
